// file: rtl/mbox_cfg.svh
`ifndef MBOX_CFG_SVH
`define MBOX_CFG_SVH

// ----------------------------------------------------------------------------
// clock and pin timing (ns, then whole cycles rounded up)
// ----------------------------------------------------------------------------
`define CLK_NS 10
`define T_SETTLE_NS 20
`define T_ACCESS_NS 20
`define T_WPULSE_NS 20
`define T_WHOLD_NS 15
`define T_RECOVER_NS 10
`define SETTLE_CYC ((`T_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACCESS_CYC ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define WPULSE_CYC ((`T_WPULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define WHOLD_CYC ((`T_WHOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4

// ----------------------------------------------------------------------------
// memory map of the device port
// ----------------------------------------------------------------------------
`define ADDR_W 16
`define DATA_W 18
`define MBOX_LEFT_ADDR 16'hFFFE
`define MBOX_RIGHT_ADDR 16'hFFFF
`define SEM_IDX_W 3
`define SEM_REQUEST_BIT 1'h0
`define SEM_RELEASE_BIT 1'h1
`define SEM_FLAG_BIT 0

`endif

// file: rtl/mbox_pkg.sv
package mbox_pkg;

   // one pin-level cycle on the device port
   typedef enum logic {
      CYC_READ,
      CYC_WRITE
   } cyc_op_e;

   // user commands
   typedef enum logic [2:0] {
      OP_MEM_RD,
      OP_MEM_WR,
      OP_SEM_TAKE,
      OP_SEM_GIVE,
      OP_SEM_PEEK,
      OP_POST_MAIL,
      OP_FETCH_MAIL
   } cmd_op_e;

endpackage

// file: rtl/port_cycle_if.sv
`timescale 1ns/10ps
interface port_cycle_if #(
   parameter int AW = 16,
   parameter int DW = 18
);
   logic req;
   mbox_pkg::cyc_op_e op;
   logic token_select;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic done;
   logic [DW-1:0] rdata;
   logic stalled;

   modport ctl (output req, output op, output token_select, output addr, output wdata,
                input done, input rdata, input stalled);
   modport eng (input req, input op, input token_select, input addr, input wdata,
                output done, output rdata, output stalled);
endinterface

// file: rtl/port_cycle.sv
`timescale 1ns/10ps
`include "mbox_cfg.svh"
module port_cycle #(
   parameter int AW = `ADDR_W,
   parameter int DW = `DATA_W
) (
   // clock and synchronised reset
   input wire logic ref_clk,
   input wire logic rst_sync_n,
   // mode
   input wire logic slave_mode,
   // cycle requests
   port_cycle_if.eng cyc,
   // device port pins
   output logic ce_n,
   output logic token_select_n,
   output logic rw_n,
   output logic oe_n,
   output logic [AW-1:0] addr,
   output logic [DW-1:0] data_o,
   output logic data_oe,
   input wire logic [DW-1:0] data_i,
   input wire logic conflict_flag_n_i
);

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STALL, ST_STROBE, ST_HOLD} cyc_state_e;

   cyc_state_e state_q;
   logic [`CNT_W-1:0] cnt_q;
   logic is_write_q;
   logic sem_q;
   logic cnt_zero;
   logic flag_clear;

   assign cnt_zero = (cnt_q == '0);
   // a flag only matters on array accesses while the device arbitrates
   assign flag_clear = slave_mode | sem_q | conflict_flag_n_i;

   // ---------------------------------------------------------------------------
   // cycle sequencer: select, settle, check flag, strobe, recover
   // ---------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         is_write_q <= 1'b0;
         sem_q <= 1'b0;
         ce_n <= 1'b1;
         token_select_n <= 1'b1;
         rw_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= '0;
         data_o <= '0;
         data_oe <= 1'b0;
         cyc.done <= 1'b0;
         cyc.rdata <= '0;
         cyc.stalled <= 1'b0;
      end else begin
         cyc.done <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (cyc.req) begin
                  is_write_q <= (cyc.op == mbox_pkg::CYC_WRITE);
                  sem_q <= cyc.token_select;
                  ce_n <= cyc.token_select;
                  token_select_n <= ~cyc.token_select;
                  oe_n <= (cyc.op == mbox_pkg::CYC_WRITE);
                  addr <= cyc.addr;
                  data_o <= cyc.wdata;
                  cyc.stalled <= 1'b0;
                  cnt_q <= `CNT_W'(`SETTLE_CYC);
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (!cnt_zero) begin
                  cnt_q <= cnt_q - `CNT_W'(1);
               end else if (!flag_clear) begin
                  // strobe withheld while the far port owns the word
                  cyc.stalled <= 1'b1;
                  state_q <= ST_STALL;
               end else if (is_write_q) begin
                  rw_n <= 1'b0;
                  data_oe <= 1'b1;
                  cnt_q <= `CNT_W'(`WPULSE_CYC - 1);
                  state_q <= ST_STROBE;
               end else begin
                  cyc.rdata <= data_i;
                  ce_n <= 1'b1;
                  token_select_n <= 1'b1;
                  oe_n <= 1'b1;
                  cnt_q <= `CNT_W'(`RECOVER_CYC);
                  state_q <= ST_HOLD;
               end
            end
            ST_STALL: begin
               // the device lets go of the flag once the match ends; resettle
               if (flag_clear) begin
                  cnt_q <= `CNT_W'(`WHOLD_CYC);
                  state_q <= ST_SETUP;
               end
            end
            ST_STROBE: begin
               if (!cnt_zero) begin
                  cnt_q <= cnt_q - `CNT_W'(1);
               end else begin
                  rw_n <= 1'b1;
                  cnt_q <= `CNT_W'(`RECOVER_CYC);
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               ce_n <= 1'b1;
               token_select_n <= 1'b1;
               oe_n <= 1'b1;
               data_oe <= 1'b0;
               if (!cnt_zero) begin
                  cnt_q <= cnt_q - `CNT_W'(1);
               end else begin
                  cyc.done <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

endmodule

// file: rtl/mbox_host.sv
`timescale 1ns/10ps
`include "mbox_cfg.svh"
module mbox_host #(
   parameter bit RIGHT_SIDE = 1'b0,
   parameter int AW = `ADDR_W,
   parameter int DW = `DATA_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration
   input wire logic slave_mode,
   input wire logic write_block,
   // command port
   input wire logic cmd_valid,
   input wire mbox_pkg::cmd_op_e cmd_op,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_wdata,
   output logic cmd_ready,
   // response port
   output logic rsp_valid,
   output logic [DW-1:0] rsp_data,
   output logic rsp_granted,
   output logic rsp_conflict,
   // status
   output logic mail_pending,
   output logic init_done,
   // device port pins
   output logic ce_n,
   output logic token_select_n,
   output logic rw_n,
   output logic oe_n,
   output logic [AW-1:0] addr,
   output logic [DW-1:0] data_o,
   output logic data_oe,
   input wire logic [DW-1:0] data_i,
   input wire logic mailbox_irq_n,
   input wire logic conflict_flag_n_i,
   output logic conflict_flag_n_o,
   output logic conflict_flag_oe
);

   // ---------------------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------------------
   if (AW != `ADDR_W || DW < 1) begin : g_bad_width
      $error("mbox_host: address width must match the mailbox map");
   end

   typedef enum logic [1:0] {M_BOOT, M_IDLE, M_RUN, M_RESP} main_state_e;

   // ---------------------------------------------------------------------------
   // reset release through two flops
   // ---------------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_n;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // ---------------------------------------------------------------------------
   // command state
   // ---------------------------------------------------------------------------
   main_state_e state_q;
   mbox_pkg::cmd_op_e op_q;
   logic [AW-1:0] caddr_q;
   logic [DW-1:0] cwdata_q;
   logic phase_q;
   logic req_q;
   logic accept;

   port_cycle_if #(.AW(AW), .DW(DW)) cyc ();

   // ---------------------------------------------------------------------------
   // cycle decode from the latched command
   // ---------------------------------------------------------------------------
   wire [AW-1:0] own_mbox = RIGHT_SIDE ? `MBOX_RIGHT_ADDR : `MBOX_LEFT_ADDR;
   wire [AW-1:0] peer_mbox = RIGHT_SIDE ? `MBOX_LEFT_ADDR : `MBOX_RIGHT_ADDR;
   wire [AW-1:0] sem_addr = {{(AW-`SEM_IDX_W){1'b0}}, caddr_q[`SEM_IDX_W-1:0]};
   wire is_sem = (op_q == mbox_pkg::OP_SEM_TAKE) || (op_q == mbox_pkg::OP_SEM_GIVE) ||
                 (op_q == mbox_pkg::OP_SEM_PEEK);
   // a take is write-then-read, never read-then-write, so no gap can be raced
   wire take_write = (op_q == mbox_pkg::OP_SEM_TAKE) && !phase_q;
   wire is_write = (op_q == mbox_pkg::OP_MEM_WR) || (op_q == mbox_pkg::OP_SEM_GIVE) ||
                   (op_q == mbox_pkg::OP_POST_MAIL) || take_write;
   wire sem_bit = (op_q == mbox_pkg::OP_SEM_GIVE) ? `SEM_RELEASE_BIT : `SEM_REQUEST_BIT;
   wire [DW-1:0] sem_word = {{(DW-1){1'b0}}, sem_bit};
   wire [AW-1:0] run_addr = is_sem ? sem_addr :
                            (op_q == mbox_pkg::OP_POST_MAIL) ? peer_mbox :
                            (op_q == mbox_pkg::OP_FETCH_MAIL) ? own_mbox :
                            caddr_q;
   wire need_second = take_write;
   wire boot_done = cyc.done && (state_q == M_BOOT);

   assign cyc.req = req_q;
   assign cyc.op = is_write ? mbox_pkg::CYC_WRITE : mbox_pkg::CYC_READ;
   assign cyc.token_select = is_sem;
   assign cyc.addr = run_addr;
   // the message itself is plain storage; posting carries user data
   assign cyc.wdata = is_sem ? sem_word : cwdata_q;
   assign accept = cmd_valid && cmd_ready;

   // ---------------------------------------------------------------------------
   // command sequencer; boot reads own mailbox so a stale irq is cleared
   // ---------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= M_BOOT;
         op_q <= mbox_pkg::OP_FETCH_MAIL;
         caddr_q <= '0;
         cwdata_q <= '0;
         phase_q <= 1'b0;
         req_q <= 1'b1;
      end else begin
         req_q <= 1'b0;
         unique case (state_q)
            M_BOOT: begin
               if (boot_done) begin
                  state_q <= M_IDLE;
               end
            end
            M_IDLE: begin
               if (accept) begin
                  op_q <= cmd_op;
                  caddr_q <= cmd_addr;
                  cwdata_q <= cmd_wdata;
                  phase_q <= 1'b0;
                  req_q <= 1'b1;
                  state_q <= M_RUN;
               end
            end
            M_RUN: begin
               if (cyc.done && need_second) begin
                  // read back through a fresh select so the latch reloads
                  phase_q <= 1'b1;
                  req_q <= 1'b1;
               end else if (cyc.done) begin
                  state_q <= M_RESP;
               end
            end
            M_RESP: begin
               state_q <= M_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------------
   // user-side outputs, all registered
   // ---------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_granted <= 1'b0;
         rsp_conflict <= 1'b0;
         init_done <= 1'b0;
      end else begin
         cmd_ready <= (state_q == M_IDLE && !accept) || (state_q == M_RESP) || boot_done;
         rsp_valid <= (state_q == M_RUN) && cyc.done && !need_second;
         if ((state_q == M_RUN) && cyc.done && !need_second) begin
            rsp_data <= cyc.rdata;
            // a token is held when this side reads it back as zero
            rsp_granted <= is_sem && !cyc.rdata[`SEM_FLAG_BIT];
            rsp_conflict <= cyc.stalled;
         end
         if (boot_done) begin
            init_done <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // mailbox flag and conflict pin drive for a slave-mode device
   // ---------------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mail_pending <= 1'b0;
         conflict_flag_n_o <= 1'b1;
         conflict_flag_oe <= 1'b0;
      end else begin
         mail_pending <= init_done && !mailbox_irq_n;
         conflict_flag_n_o <= !write_block;
         conflict_flag_oe <= slave_mode;
      end
   end

   // ---------------------------------------------------------------------------
   // pin cycle engine
   // ---------------------------------------------------------------------------
   port_cycle #(.AW(AW), .DW(DW)) u_cycle (
      .ref_clk(ref_clk),
      .rst_sync_n(rst_sync_n),
      .slave_mode(slave_mode),
      .cyc(cyc),
      .ce_n(ce_n),
      .token_select_n(token_select_n),
      .rw_n(rw_n),
      .oe_n(oe_n),
      .addr(addr),
      .data_o(data_o),
      .data_oe(data_oe),
      .data_i(data_i),
      .conflict_flag_n_i(conflict_flag_n_i)
   );

endmodule

// file: verif/dual_port_dev.sv
`timescale 1ns/10ps
// behavioural two-port memory, left port on pins, right port by task calls
module dual_port_dev (
   // clock
   input wire logic ref_clk,
   // left port pins
   input wire logic ce_n,
   input wire logic token_select_n,
   input wire logic rw_n,
   input wire logic oe_n,
   input wire logic [15:0] addr,
   input wire logic [17:0] data_o,
   input wire logic slave_mode,
   input wire logic flag_pin_n,
   output logic [17:0] data_i = 18'h0,
   output logic mailbox_irq_n = 1'b0, // power-up state left dirty
   output logic busy_n = 1'b1
);
   // ------------------------------------------
   // state
   // ------------------------------------------
   logic [17:0] mem [logic [15:0]];
   logic [1:0] owner [8] = '{default: 2'd0};
   logic req [2][8] = '{default: 1'b0};
   logic [17:0] wdat = 18'h0;
   logic r_sel = 1'b0, right_irq_n = 1'b1;
   logic [15:0] r_addr = 16'h0;
   logic rw_q = 1'b1, blk = 1'b0, rd_q = 1'b0, lsel_q = 1'b0;

   // decode; token space needs array deselected
   wire sel_mem = !ce_n;
   wire sel_tok = ce_n && !token_select_n;
   wire tok_rd = sel_tok && !oe_n;
   wire match = sel_mem && r_sel && addr == r_addr; // read/write ignored
   wire inhibit = slave_mode ? !flag_pin_n : !busy_n;

   // a 0 from the non-owner only parks a request
   function automatic void sem_wr(input int s, input logic [2:0] i, input logic b);
      req[s][i] = !b;
      if (!b && owner[i] == 2'd0)
         owner[i] = 2'(s + 1);
      else if (b && owner[i] == 2'(s + 1))
         owner[i] = req[1-s][i] ? 2'(2 - s) : 2'd0;
   endfunction
   function automatic logic right_flag(input int i);
      return owner[i] != 2'd2;
   endfunction
   task automatic right_sem(input logic [2:0] i, input logic b);
      sem_wr(1, i, b);
   endtask
   // right port writes the left mailbox word
   task automatic right_post(input logic [17:0] d);
      mem[16'hFFFE] = d;
      mailbox_irq_n = 1'b0;
   endtask
   task automatic right_select(input logic s, input logic [15:0] a);
      r_sel = s;
      r_addr = a;
   endtask

   // later arrival is flagged; only the left flag is modelled, so both never
   // go low together
   always @(posedge ref_clk) begin
      lsel_q <= sel_mem;
      busy_n <= !(match && (!busy_n || !lsel_q));
   end

   // reads: token value latched on select plus enable, idle data churns
   always @(posedge ref_clk) begin
      rd_q <= tok_rd;
      if (tok_rd && !rd_q)
         data_i <= {18{owner[addr[2:0]] != 2'd1}};
      else if (sel_mem && !oe_n)
         data_i <= mem.exists(addr) ? mem[addr] : 18'h0;
      else if (!tok_rd)
         data_i <= ~data_i;
      if (sel_mem && !oe_n && addr == 16'hFFFE)
         mailbox_irq_n <= 1'b1;
   end

   // writes commit at the strobe's trailing edge unless inhibited meanwhile
   always @(posedge ref_clk) begin
      rw_q <= rw_n;
      if ((sel_mem || sel_tok) && !rw_n) begin
         wdat <= data_o;
         blk <= blk || (sel_mem && inhibit);
      end
      if (!rw_q && rw_n) begin
         blk <= 1'b0;
         if (sel_tok)
            sem_wr(0, addr[2:0], wdat[0]);
         else if (sel_mem && !blk) begin
            mem[addr] = wdat;
            if (addr == 16'hFFFF)
               right_irq_n <= 1'b0;
         end
      end
   end
endmodule

// file: verif/mbox_host_assertions.sv
`timescale 1ns/10ps
module mbox_host_assertions #(
   parameter int AW = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // configuration and user side
   input wire logic slave_mode,
   input wire logic write_block,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic rsp_granted,
   input wire logic rsp_conflict,
   input wire logic mail_pending,
   input wire logic init_done,
   // device pins
   input wire logic ce_n,
   input wire logic token_select_n,
   input wire logic rw_n,
   input wire logic [AW-1:0] addr,
   input wire logic data_oe,
   input wire logic oe_n,
   input wire logic mailbox_irq_n,
   input wire logic conflict_flag_n_i,
   input wire logic conflict_flag_n_o,
   input wire logic conflict_flag_oe
);
   // ------------------------------------------
   // pin protocol checks
   // ------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // either select low means a pin cycle is open
   wire any_sel = !ce_n || !token_select_n;

   a_token_link: assert property (!token_select_n |-> ce_n)
      else $error("array and token selected together");
   a_strobe_setup: assert property (
      $fell(rw_n) |-> $past(any_sel, 2) && $stable(addr))
      else $error("strobe before select settled");
   a_strobe_len: assert property ($fell(rw_n) |-> !rw_n [*2] ##1 rw_n)
      else $error("write strobe width wrong");
   a_stall_flag: assert property (
      (!slave_mode && !ce_n && rw_n && !conflict_flag_n_i) [*3] |=> rw_n)
      else $error("strobe while conflict flag low");
   a_data_own: assert property (data_oe |-> oe_n && any_sel)
      else $error("data driven outside a write");
   a_slave_oe: assert property (1'b1 |=> conflict_flag_oe == $past(slave_mode))
      else $error("conflict pin drive not following slave mode");
   a_block_level: assert property (
      conflict_flag_oe && $past(conflict_flag_oe) && $stable(write_block)
      |-> conflict_flag_n_o == !write_block)
      else $error("conflict pin level not following write block");
   a_mail_level: assert property (
      (init_done && $stable(mailbox_irq_n)) [*3] |-> mail_pending == !mailbox_irq_n)
      else $error("mail pending not following irq pin");
   a_init_ready: assert property ($rose(init_done) |-> cmd_ready ##1 init_done)
      else $error("init done without ready");

   // main scenarios reached
   c_conflict: cover property (rsp_valid && rsp_conflict);
   c_granted: cover property (rsp_valid && rsp_granted);
   c_mail: cover property ($rose(mail_pending));
   c_block: cover property (conflict_flag_oe && !conflict_flag_n_o);
endmodule

bind mbox_host mbox_host_assertions #(.AW(AW)) chk (
   .ref_clk, .rst_n, .slave_mode, .write_block, .cmd_ready, .rsp_valid,
   .rsp_granted, .rsp_conflict, .mail_pending, .init_done, .ce_n,
   .token_select_n, .rw_n, .addr, .data_oe, .oe_n, .mailbox_irq_n,
   .conflict_flag_n_i, .conflict_flag_n_o, .conflict_flag_oe
);

// file: verif/tb_mbox_host.sv
`timescale 1ns/10ps
module tb_mbox_host;
   // ------------------------------------------
   // signals, design and device model
   // ------------------------------------------
   logic ref_clk, rst_n, slave_mode, write_block, cmd_valid;
   mbox_pkg::cmd_op_e cmd_op;
   logic [15:0] cmd_addr, addr;
   logic [17:0] cmd_wdata, rsp_data, data_o, data_i;
   logic cmd_ready, rsp_valid, rsp_granted, rsp_conflict, mail_pending, init_done;
   logic ce_n, token_select_n, rw_n, oe_n, data_oe, irq_n;
   logic flag_n_o, flag_oe, busy_n, flag_pin_n;
   int mismatches = 0;
   int check_count = 0;

   // single device, host drives the pin only in slave mode
   assign flag_pin_n = flag_oe ? flag_n_o : busy_n;

   mbox_host uut (.ref_clk(ref_clk), .rst_n(rst_n), .slave_mode(slave_mode),
      .write_block(write_block), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_granted(rsp_granted),
      .rsp_conflict(rsp_conflict), .mail_pending(mail_pending),
      .init_done(init_done), .ce_n(ce_n), .token_select_n(token_select_n),
      .rw_n(rw_n), .oe_n(oe_n), .addr(addr), .data_o(data_o), .data_oe(data_oe),
      .data_i(data_i), .mailbox_irq_n(irq_n), .conflict_flag_n_i(flag_pin_n),
      .conflict_flag_n_o(flag_n_o), .conflict_flag_oe(flag_oe));
   dual_port_dev dev (.ref_clk(ref_clk), .ce_n(ce_n),
      .token_select_n(token_select_n), .rw_n(rw_n), .oe_n(oe_n), .addr(addr),
      .data_o(data_o), .slave_mode(slave_mode), .flag_pin_n(flag_pin_n),
      .data_i(data_i), .mailbox_irq_n(irq_n), .busy_n(busy_n));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ------------------------------------------
   // shared tasks
   // ------------------------------------------
   task automatic chk_data(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   // one command, held until taken, then waits for its response
   task automatic do_cmd(input mbox_pkg::cmd_op_e op, input logic [15:0] a,
                         input logic [17:0] d);
      int n;
      n = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      #1 cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
      #1;
      chk_bit(n < 400, 1'b1);
   endtask
   // right port parks on the same word, released after a while
   task automatic conflict_cmd(input mbox_pkg::cmd_op_e op, input logic [17:0] d);
      dev.right_select(1'b1, 16'h0040);
      fork
         do_cmd(op, 16'h0040, d);
         begin
            repeat (20) @(posedge ref_clk);
            #1 dev.right_select(1'b0, 16'h0040);
         end
      join
   endtask
   task automatic settle();
      repeat (5) @(posedge ref_clk);
      #1;
   endtask

   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_boot();
      int n;
      n = 0;
      while (init_done !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      settle();
      chk_bit(init_done, 1'b1);
      chk_bit(irq_n, 1'b1);
      chk_bit(mail_pending, 1'b0);
      $display("test boot done");
   endtask
   task automatic t_mail();
      do_cmd(mbox_pkg::OP_MEM_WR, 16'h0012, 18'h2A5A5);
      do_cmd(mbox_pkg::OP_MEM_RD, 16'h0012, 18'h0);
      chk_data(rsp_data, 18'h2A5A5);
      dev.right_post(18'h3C0F1);
      settle();
      chk_bit(mail_pending, 1'b1);
      do_cmd(mbox_pkg::OP_FETCH_MAIL, 16'h0, 18'h0);
      chk_data(rsp_data, 18'h3C0F1);
      settle();
      chk_bit(mail_pending, 1'b0);
      chk_bit(dev.right_irq_n, 1'b1);
      do_cmd(mbox_pkg::OP_POST_MAIL, 16'h0, 18'h0BEEF);
      chk_bit(dev.right_irq_n, 1'b0);
      chk_data(dev.mem[16'hFFFF], 18'h0BEEF);
      $display("test mailbox done");
   endtask
   task automatic t_sem();
      for (int i = 0; i < 8; i++) begin
         do_cmd(mbox_pkg::OP_SEM_TAKE, 16'(i), 18'h0);
         chk_bit(rsp_granted, 1'b1);
         chk_data(rsp_data, 18'h0);
         chk_bit(dev.right_flag(i), 1'b1);
         do_cmd(mbox_pkg::OP_SEM_GIVE, 16'(i), 18'h0);
         do_cmd(mbox_pkg::OP_SEM_PEEK, 16'(i), 18'h0);
         chk_data(rsp_data, 18'h3FFFF);
      end
      dev.right_sem(3'h5, 1'b0);
      do_cmd(mbox_pkg::OP_SEM_TAKE, 16'h0005, 18'h0);
      chk_bit(rsp_granted, 1'b0);
      chk_bit(dev.right_flag(5), 1'b0);
      dev.right_sem(3'h5, 1'b1);
      do_cmd(mbox_pkg::OP_SEM_PEEK, 16'h0005, 18'h0);
      chk_bit(rsp_granted, 1'b1);
      chk_bit(dev.right_flag(5), 1'b1);
      do_cmd(mbox_pkg::OP_SEM_GIVE, 16'h0005, 18'h0);
      $display("test tokens done");
   endtask
   task automatic t_conflict();
      conflict_cmd(mbox_pkg::OP_MEM_WR, 18'h15555);
      chk_bit(rsp_conflict, 1'b1);
      chk_data(dev.mem[16'h0040], 18'h15555);
      dev.right_select(1'b1, 16'h0041);
      do_cmd(mbox_pkg::OP_MEM_WR, 16'h0040, 18'h0AAAA);
      chk_bit(rsp_conflict, 1'b0);
      conflict_cmd(mbox_pkg::OP_MEM_RD, 18'h0);
      chk_bit(rsp_conflict, 1'b1);
      chk_data(rsp_data, 18'h0AAAA);
      $display("test conflict done");
   endtask
   task automatic t_slave();
      do_cmd(mbox_pkg::OP_MEM_WR, 16'h0080, 18'h2D2D2);
      slave_mode = 1'b1;
      write_block = 1'b1;
      settle();
      do_cmd(mbox_pkg::OP_MEM_WR, 16'h0080, 18'h12345);
      do_cmd(mbox_pkg::OP_MEM_RD, 16'h0080, 18'h0);
      chk_data(rsp_data, 18'h2D2D2);
      write_block = 1'b0;
      settle();
      do_cmd(mbox_pkg::OP_MEM_WR, 16'h0080, 18'h12345);
      do_cmd(mbox_pkg::OP_MEM_RD, 16'h0080, 18'h0);
      chk_data(rsp_data, 18'h12345);
      slave_mode = 1'b0;
      settle();
      $display("test slave done");
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // main sequence; inputs move 1 ns after the rising edge
   initial begin
      rst_n = 1'b0;
      slave_mode = 1'b0;
      write_block = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = mbox_pkg::OP_MEM_RD;
      cmd_addr = 16'h0;
      cmd_wdata = 18'h0;
      repeat (6) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      t_boot();
      t_mail();
      t_sem();
      t_conflict();
      t_slave();
      give_verdict();
   end

   // watchdog: the tests need well under a tenth of this span
   initial begin
      #300000;
      mismatches++;
      give_verdict();
   end
endmodule
